// >>> owc_pkg.sv
// package: option word field layout and decode encodings
package owc_pkg;
  // ****************************************
  // word layout
  // ****************************************
  localparam int WORD_W        = 13;
  localparam int PROT_LO       = 0;
  localparam int PROT_W        = 3;
  localparam int PWR_BIT       = 3;
  localparam int OSC_LO        = 4;
  localparam int OSC_W         = 3;
  localparam int WDT_BIT       = 7;
  localparam int IPER_BIT      = 8;
  localparam int IRCF_LO       = 0;
  localparam int IRCF_W        = 2;
  localparam int CYC_BIT       = 6;
  localparam int CKO_BIT       = 11;
  localparam int TRIM_W        = 4;
  localparam logic [2:0] PROT_OFF = 3'h7;
  // ****************************************
  // reset values (documented defaults)
  // ****************************************
  localparam logic [12:0] WORD0_RST = 13'h1_FFF;
  localparam logic [12:0] WORD1_RST = 13'h0_843;
  localparam logic [3:0]  TRIM_RST  = 4'hF;
  // oscillator mode codes
  localparam logic [2:0] OSC_LXT  = 3'h6;
  localparam logic [2:0] OSC_HXT  = 3'h7;
  // timer prescale from oscillator
  localparam logic [2:0] DIV_TWO  = 3'h2;
  localparam logic [2:0] DIV_FOUR = 3'h4;
  // one-hot oscillator class
  typedef enum logic [4:0] {
    EXT_RC  = 5'h01,
    INT_RC  = 5'h02,
    TRIM_RC = 5'h04,
    LOW_XT  = 5'h08,
    HIGH_XT = 5'h10
  } owc_osc_t;
  // internal rc nominal frequency
  typedef enum logic [1:0] {
    IRC_455K = 2'h0,
    IRC_1M   = 2'h1,
    IRC_8M   = 2'h2,
    IRC_4M   = 2'h3
  } owc_ircf_t;
endpackage : owc_pkg

// >>> owc_trim_if.sv
// interface: trim code to frequency step between decoder and step mapper
`timescale 1ns/1ps
interface owc_trim_if;
  logic [3:0] trimCode;
  logic [3:0] stepIndex;
  modport core (output trimCode, input stepIndex);
  modport map  (input trimCode, output stepIndex);
endinterface : owc_trim_if

// >>> owc_trim_map.sv
// module: maps the rc trim code to a monotonic step index
`timescale 1ns/1ps
module owc_trim_map (
  owc_trim_if.map trim
);
  import owc_pkg::*;
  // top bit clear counts up from step 0; top bit set counts down from the
  // top step, so the all-ones code lands on step 8, the nominal frequency
  always_comb begin
    if (trim.trimCode[TRIM_W-1]) begin
      trim.stepIndex = ~{1'b0, trim.trimCode[TRIM_W-2:0]};
    end else begin
      trim.stepIndex = trim.trimCode;
    end
  end
endmodule : owc_trim_map

// >>> option_word_clock_config.sv
// module: option word decoder producing static clock configuration
//
// Notes on behaviour
// - option words come only from programming ports, never from instructions.
// - protection on unless all three protect bits are one.
// - power level bit 0 means low power, 1 high power.
// - oscillator field selects ext rc, int rc, trimmed rc, low or high crystal.
// - in rc modes field lsb makes shared pin oscillator output.
// - watchdog enabled when its disable bit is zero.
// - instruction period four oscillator periods when bit set, else two.
// - two-bit select picks 4, 8, 1 MHz or 455 kHz.
// - internal rc defaults to 4 MHz, each frequency trimmed by 4 bits.
// - trim code maps to sixteen monotonic steps, top bit counts down.
// - cycle select zero gives one instruction cycle, one gives two.
// - in rc modes clock out bit drives clock, else pin open drain.
// - word 2 is a user id with no behavioural effect.
// - four-period option clocks timer at osc over four.
`timescale 1ns/1ps
module option_word_clock_config (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     clkEn,
  input  wire logic [owc_pkg::WORD_W-1:0] optWord0,
  input  wire logic [owc_pkg::WORD_W-1:0] optWord1,
  input  wire logic [owc_pkg::WORD_W-1:0] optWord2,
  input  wire logic [3:0]               rcTrimField,
  output logic                          codeProtect,
  output logic                          highPower,
  output owc_pkg::owc_osc_t             oscClass,
  output logic                          oscOutPinSel,
  output logic                          wdtEnable,
  output logic                          fourPeriodInstr,
  output logic [2:0]                    timerDiv,
  output owc_pkg::owc_ircf_t            ircFreq,
  output logic [3:0]                    rcTrimStep,
  output logic                          twoCycleInstr,
  output logic                          clkOutDrive,
  output logic                          clkOutOe_n,
  output logic [owc_pkg::WORD_W-1:0]    userId
);
  import owc_pkg::*;

  // ****************************************
  // option word capture
  // ****************************************
  // words are captured only while reset is high; run-time code has no path
  logic [WORD_W-1:0] word0, word1, word2;
  logic [3:0]        trim;
  logic [WORD_W-1:0] next_word0, next_word1, next_word2;
  logic [3:0]        next_trim;
  logic              sampled, next_sampled;

  logic [WORD_W-1:0] metaWord0, metaWord1, metaWord2;
  logic [WORD_W-1:0] syncWord0, syncWord1, syncWord2;
  logic [3:0]        metaTrim, syncTrim;

  // straps arrive from outside the clock domain, so two flops first;
  // limitation: reset must span three enabled edges to capture new straps
  always_ff @(posedge core_clk) begin
    if (clkEn) begin
      metaWord0 <= optWord0;
      metaWord1 <= optWord1;
      metaWord2 <= optWord2;
      metaTrim  <= rcTrimField;
      syncWord0 <= metaWord0;
      syncWord1 <= metaWord1;
      syncWord2 <= metaWord2;
      syncTrim  <= metaTrim;
    end
  end

  // capture only from the second synchroniser stage
  always_comb begin
    next_word0   = word0;
    next_word1   = word1;
    next_word2   = word2;
    next_trim    = trim;
    next_sampled = sampled;
    if (rst) begin
      next_word0   = syncWord0;
      next_word1   = syncWord1;
      next_word2   = syncWord2;
      next_trim    = syncTrim;
      next_sampled = 1'b1;
    end
  end

  // reset sampling is clocked, so the flops only ever load at an edge
  always_ff @(posedge core_clk) begin
    if (clkEn) begin
      word0   <= next_word0;
      word1   <= next_word1;
      word2   <= next_word2;
      trim    <= next_trim;
      sampled <= next_sampled;
    end
  end

  // ****************************************
  // trim step mapping
  // ****************************************
  owc_trim_if trimBus ();
  owc_trim_map uTrimMap (
    .trim (trimBus.map)
  );

  // ****************************************
  // field decode
  // ****************************************
  logic [OSC_W-1:0] oscField;
  logic             rcMode;
  owc_osc_t         oscDec;
  owc_osc_t         oscW;
  logic [WORD_W-1:0] w0, w1;

  // until the first sample, decode the documented defaults
  always_comb begin
    w0               = sampled ? word0 : WORD0_RST;
    w1               = sampled ? word1 : WORD1_RST;
    trimBus.trimCode = sampled ? trim : TRIM_RST;
    oscField         = w0[OSC_LO +: OSC_W];
  end

  // field msbs pick the class, lsb picks pin use in rc modes and low or high crystal otherwise
  always_comb begin
    unique case (oscField[2:1])
      2'h0: oscDec = EXT_RC;
      2'h1: oscDec = INT_RC;
      2'h2: oscDec = TRIM_RC;
      2'h3: oscDec = (oscField == OSC_LXT) ? LOW_XT : HIGH_XT;
    endcase
    oscW   = oscDec;
    rcMode = (oscDec != LOW_XT) && (oscDec != HIGH_XT);
  end

  // ****************************************
  // output registers
  // ****************************************
  logic              next_codeProtect, next_highPower, next_oscOutPinSel;
  logic              next_wdtEnable, next_fourPeriodInstr;
  logic              next_twoCycleInstr, next_clkOutDrive, next_clkOutOe_n;
  owc_osc_t          next_oscClass;
  owc_ircf_t         next_ircFreq;
  logic [2:0]        next_timerDiv;
  logic [3:0]        next_rcTrimStep;
  logic [WORD_W-1:0] next_userId;

  // next output values straight from the decoded fields
  always_comb begin
    next_codeProtect     = w0[PROT_LO +: PROT_W] != PROT_OFF;
    next_highPower       = w0[PWR_BIT];
    next_oscClass        = oscW;
    next_oscOutPinSel    = rcMode && oscField[0];
    next_wdtEnable       = ~w0[WDT_BIT];
    next_fourPeriodInstr = w0[IPER_BIT];
    next_timerDiv        = w0[IPER_BIT] ? DIV_FOUR : DIV_TWO;
    next_ircFreq         = owc_ircf_t'(w1[IRCF_LO +: IRCF_W]);
    next_rcTrimStep      = trimBus.stepIndex;
    next_twoCycleInstr   = w1[CYC_BIT];
    next_clkOutDrive     = rcMode && w1[CKO_BIT];
    next_clkOutOe_n      = ~(rcMode && w1[CKO_BIT]);
    next_userId          = sampled ? word2 : '0;
  end

  // registered outputs; held because words no longer change after reset
  always_ff @(posedge core_clk) begin
    if (clkEn) begin
      codeProtect     <= next_codeProtect;
      highPower       <= next_highPower;
      oscClass        <= next_oscClass;
      oscOutPinSel    <= next_oscOutPinSel;
      wdtEnable       <= next_wdtEnable;
      fourPeriodInstr <= next_fourPeriodInstr;
      timerDiv        <= next_timerDiv;
      ircFreq         <= next_ircFreq;
      rcTrimStep      <= next_rcTrimStep;
      twoCycleInstr   <= next_twoCycleInstr;
      clkOutDrive     <= next_clkOutDrive;
      clkOutOe_n      <= next_clkOutOe_n; // low while the pin is driven
      userId          <= next_userId;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // decode checks compare an output with its field one edge earlier; the others check stability, one-hot coding or agreement between outputs
  protect_decode_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clkEn |=> codeProtect == ($past(w0[PROT_LO +: PROT_W]) != PROT_OFF))
    else $error("protect decode wrong");
  hold_stable_a: assert property (
    @(posedge core_clk)
    !rst && !$past(rst) && !$past(rst, 2) |->
      $stable(wdtEnable) && $stable(oscClass) && $stable(userId))
    else $error("configuration moved outside reset");
  timer_div_a: assert property (
    @(posedge core_clk) disable iff (rst)
    fourPeriodInstr == (timerDiv == DIV_FOUR))
    else $error("timer divide disagrees");
  pin_role_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (oscClass == HIGH_XT || oscClass == LOW_XT) |-> !oscOutPinSel)
    else $error("crystal mode claimed pin");
  clk_out_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clkOutDrive == !clkOutOe_n)
    else $error("clock out enable mismatch");
  wdt_bit_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clkEn |=> wdtEnable == !$past(w0[WDT_BIT]))
    else $error("watchdog decode wrong");
  power_bit_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clkEn |=> highPower == $past(w0[PWR_BIT]))
    else $error("power decode wrong");
  cycle_bit_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clkEn |=> twoCycleInstr == $past(w1[CYC_BIT]))
    else $error("cycle decode wrong");
  // a broken class decode would show up as zero or several hot bits
  osc_onehot_a: assert property (
    @(posedge core_clk) disable iff (rst)
    $onehot(oscClass))
    else $error("oscillator class not one-hot");
  four_period_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clkEn |=> fourPeriodInstr == $past(w0[IPER_BIT]))
    else $error("instruction period decode wrong");
  irc_freq_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clkEn |=> ircFreq == $past(w1[IRCF_LO +: IRCF_W]))
    else $error("rc frequency decode wrong");
  // the upper half of the codes must land in the upper half of the steps
  trim_half_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clkEn |=> rcTrimStep[TRIM_W-1] == $past(trimBus.trimCode[TRIM_W-1]))
    else $error("trim step order wrong");
  user_id_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clkEn && sampled |=> userId == $past(word2))
    else $error("user id copy wrong");
endmodule : option_word_clock_config

// >>> option_word_clock_config_bench.sv
// testbench: self-checking bench for the option word decoder
`timescale 1ns/1ps
module option_word_clock_config_bench;
  import owc_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic               core_clk = 1'b0;
  logic               rst      = 1'b1;
  logic               clkEn    = 1'b1;
  logic [12:0]        optWord0 = WORD0_RST;
  logic [12:0]        optWord1 = WORD1_RST;
  logic [12:0]        optWord2 = 13'h0_000;
  logic [3:0]         rcTrimField = TRIM_RST;
  logic               codeProtect, highPower, oscOutPinSel, wdtEnable;
  logic               fourPeriodInstr, twoCycleInstr, clkOutDrive, clkOutOe_n;
  logic [2:0]         timerDiv;
  logic [3:0]         rcTrimStep;
  logic [12:0]        userId;
  owc_osc_t           oscClass;
  owc_ircf_t          ircFreq;
  int                 error_cnt = 0;
  int                 samples_checked = 0;
  logic [12:0]        w0, w1, w2;
  logic [3:0]         tr;

  // 20 mhz clock
  always #25 core_clk = ~core_clk;

  option_word_clock_config dut (.core_clk(core_clk), .rst(rst),
    .clkEn(clkEn), .optWord0(optWord0), .optWord1(optWord1),
    .optWord2(optWord2), .rcTrimField(rcTrimField),
    .codeProtect(codeProtect), .highPower(highPower), .oscClass(oscClass),
    .oscOutPinSel(oscOutPinSel), .wdtEnable(wdtEnable),
    .fourPeriodInstr(fourPeriodInstr), .timerDiv(timerDiv),
    .ircFreq(ircFreq), .rcTrimStep(rcTrimStep),
    .twoCycleInstr(twoCycleInstr), .clkOutDrive(clkOutDrive),
    .clkOutOe_n(clkOutOe_n), .userId(userId));

  `define CHK(act, exp) begin samples_checked++; \
    if ((act) !== (exp)) begin error_cnt++; \
      $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp); end end

  // ****************************************
  // tasks
  // ****************************************
  // straps change only at the falling edge, then a full reset pulse
  task load();
    optWord0 = w0; optWord1 = w1; optWord2 = w2; rcTrimField = tr;
    rst = 1'b1; clkEn = 1'b1;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask : load

  // expectations rebuilt from the field layout, never from outputs
  task check_all();
    logic      rc;
    owc_osc_t  cls;
    case (w0[6:4])
      3'h0, 3'h1: cls = EXT_RC;
      3'h2, 3'h3: cls = INT_RC;
      3'h4, 3'h5: cls = TRIM_RC;
      3'h6:       cls = LOW_XT;
      default:    cls = HIGH_XT;
    endcase
    rc = (w0[6:4] < OSC_LXT);
    `CHK(codeProtect, w0[2:0] != 3'h7)
    `CHK(highPower, w0[3])
    `CHK(oscClass, cls)
    `CHK(oscOutPinSel, rc & w0[4])
    `CHK(wdtEnable, ~w0[7])
    `CHK(fourPeriodInstr, w0[8])
    `CHK(timerDiv, w0[8] ? 3'h4 : 3'h2)
    `CHK(ircFreq, w1[1:0])
    `CHK(rcTrimStep, tr[3] ? 4'h7 - tr : tr)
    `CHK(twoCycleInstr, w1[6])
    `CHK(clkOutDrive, rc & w1[11])
    `CHK(clkOutOe_n, ~(rc & w1[11]))
    `CHK(userId, w2)
  endtask : check_all

  task end_sim();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // ****************************************
  // tests
  // ****************************************
  // every oscillator mode and every trim code, other fields mixed in
  initial begin
    repeat (5) @(negedge core_clk);
    for (int i = 0; i < 16; i++) begin
      w0 = {4'hF, i[3], i[0], i[2:0], i[1], i[3] ? 3'h7 : i[2:0]};
      w1 = {1'b0, i[1], 4'h0, i[2], 4'h0, i[1:0]};
      w2 = 13'h0_ABC ^ 13'(i);
      tr = 4'(i);
      load();
      check_all();
    end
    // straps moving after reset must not reach the outputs
    optWord0 = ~w0; optWord1 = ~w1; optWord2 = ~w2; rcTrimField = ~tr;
    repeat (3) @(negedge core_clk);
    check_all();
    // reset with clock enable low freezes the captured state
    rst = 1'b1; clkEn = 1'b0;
    repeat (3) @(negedge core_clk);
    check_all();
    // documented defaults: high crystal, 4 mhz, nominal trim
    w0 = WORD0_RST; w1 = WORD1_RST; w2 = 13'h0_000; tr = TRIM_RST;
    load();
    check_all();
    `CHK(ircFreq, IRC_4M)
    `CHK(rcTrimStep, 4'h8)
    end_sim();
  end

  // watchdog well beyond the roughly 96 cycles of the tests
  initial begin
    #(50 * 2000);
    error_cnt++;
    end_sim();
  end
endmodule : option_word_clock_config_bench
